// ---- src/uart_tx_consts.vh ----
// Constants for the serial transmit control and status block.
// Assumes inclusion by bare name from the design files under src/.
`ifndef UART_TX_CONSTS_VH
`define UART_TX_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_STATUS_CONTROL 4'h0
`define ADDR_TX_DATA 4'h4
`define ADDR_BAUD_DIV 4'h8
`define ADDR_IRQ_STATUS 4'hc
`define ADDR_IRQ_MASK 4'hc

// ****************************************
// Status and control field positions
// ****************************************
`define BIT_IRQ_SEL_HI 15
`define BIT_IDLE_INVERT 14
`define BIT_IRQ_SEL_LO 13
`define BIT_UNIMPL 12
`define BIT_BREAK_REQ 11
`define BIT_TX_ENABLE 10
`define BIT_BUF_FULL 9
`define BIT_SHIFT_EMPTY 8
`define BIT_IR_ENABLE 0

// ****************************************
// Interrupt select encodings
// ****************************************
`define IRQSEL_ANY_MOVE 2'b00
`define IRQSEL_ALL_DONE 2'b01
`define IRQSEL_BUF_EMPTY 2'b10

// ****************************************
// Reset values and framing
// ****************************************
`define RST_BAUD_DIV 16'h001a
`define BREAK_ZERO_BITS 12
`define DATA_BITS 8
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ---- src/tx_fifo.v ----
// Transmit holding buffer, flip-flop storage with index pointers.
// Assumes one clock; flush empties it in the next cycle.
module tx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Level flags
  output wire full,
  output wire empty
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  // Handshake terms
  assign full = (count_ff == DEPTH[AW:0]);
  assign empty = (count_ff == {(AW+1){1'b0}});
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  // Storage writes, one generate entry per slot
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_slot
      localparam [AW-1:0] SLOT = gi;
      always @(posedge aclk) begin
        if (!aresetn) begin
          mem_ff[gi] <= {WIDTH{1'b0}};
        end else if (push && wr_ptr_ff == SLOT) begin
          mem_ff[gi] <= in_data;
        end
      end
    end
  endgenerate

  // Pointers and occupancy
  always @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// ---- src/tx_shifter.v ----
// Serial frame shifter: start, data or twelve-zero break, stop.
// Assumes a bit period of div+1 clocks; abort returns it to idle at once.
module tx_shifter #(
  parameter DIV_W = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire abort,
  input wire [DIV_W-1:0] div,
  // Character load
  input wire load,
  input wire load_break,
  input wire [7:0] load_data,
  // Status and line
  output wire busy,
  output reg done_ff,
  output reg line_ff
);
  reg [DIV_W-1:0] baud_cnt_ff;
  reg [3:0] bits_left_ff;
  reg [13:0] shift_ff;
  reg busy_ff;

  assign busy = busy_ff;

  // Frame shifting, LSB first; shift_ff holds remaining bits after start
  always @(posedge aclk) begin
    if (!aresetn || abort) begin
      baud_cnt_ff <= {DIV_W{1'b0}};
      bits_left_ff <= 4'h0;
      shift_ff <= 14'h3fff;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      line_ff <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      if (!busy_ff) begin
        line_ff <= 1'b1;
        if (load) begin
          busy_ff <= 1'b1;
          line_ff <= 1'b0;
          baud_cnt_ff <= div;
          if (load_break) begin
            // Twelve zeros then stop
            shift_ff <= 14'h1000;
            bits_left_ff <= 4'd13;
          end else begin
            shift_ff <= {5'h1f, 1'b1, load_data};
            bits_left_ff <= 4'd9;
          end
        end
      end else if (baud_cnt_ff != {DIV_W{1'b0}}) begin
        baud_cnt_ff <= baud_cnt_ff - 1'b1;
      end else if (bits_left_ff == 4'h0) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
        line_ff <= 1'b1;
      end else begin
        baud_cnt_ff <= div;
        line_ff <= shift_ff[0];
        shift_ff <= {1'b1, shift_ff[13:1]};
        bits_left_ff <= bits_left_ff - 1'b1;
      end
    end
  end
endmodule

// ---- src/uart_tx_status_control.v ----
// Transmit control and status of an asynchronous serial port, AXI4-Lite slave.
// Assumes one clock aclk; a remote receiver listens on the serial line.
//
// Overview of operation
// - Select 10: interrupt when buffer drains empty
// - Select 01: interrupt when all transmission finished; a break frame finishing last gives none
// - Select 00: interrupt on every character load into the shifter; break loads give none
// - Plain mode: invert gives idle low, else high
// - Encoded mode: invert gives idle high, else low
// - Break request: start, twelve zeros, stop
// - Break request clears itself after break completes
// - Enable set: transmitter owns the pin
// - Enable clear: abort, flush, release pin
// - Buffer-full flag follows buffer full state
// - Shift-empty set only when all empty
// - Shift-empty low while sending or queued
// - Bit 12 reads zero, writes ignored
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`include "uart_tx_consts.vh"

module uart_tx_status_control #(
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial line and port handover
  output wire serial_tx_pin,
  output wire tx_pin_owned,
  // Interrupts
  output reg tx_irq_pulse_ff,
  output wire irq
);
  // ****************************************
  // Registers and wires
  // ****************************************
  reg [1:0] tx_irq_select_ff;
  reg tx_idle_invert_ff;
  reg tx_break_request_ff;
  reg break_active_ff;
  reg tx_enable_bit_ff;
  reg infrared_encode_enable_ff;
  reg [15:0] baud_div_ff;
  reg [1:0] irq_status_ff;
  reg [1:0] irq_mask_ff;
  reg [3:0] aw_addr_ff;
  reg aw_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg w_held_ff;
  reg [AW:0] buf_level_ff;
  reg tx_ir_ff;
  reg [15:0] ir_cnt_ff;
  reg [15:0] status_word;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  wire wr_fire;
  wire rd_fire;
  wire data_wr;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_full;
  wire fifo_empty;
  wire shifter_busy;
  wire shifter_done;
  wire shifter_line;
  wire load_char;
  wire load_break;
  wire buf_empty_after;
  wire buf_push;
  wire tx_shift_empty_flag;
  wire tx_event;
  wire plain_line;
  wire ir_line;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************

  // Address and data accepted in either order, one write in flight
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held_ff && w_held_ff;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign data_wr = wr_fire && aw_addr_ff == `ADDR_TX_DATA && w_strb_ff[0];

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= 4'h0;
      aw_held_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      w_held_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_ff)
          `ADDR_STATUS_CONTROL, `ADDR_TX_DATA, `ADDR_BAUD_DIV, `ADDR_IRQ_STATUS: begin
            s_axi_bresp <= `AXI_OKAY;
          end
          default: begin
            s_axi_bresp <= `AXI_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Status word as software sees it; bit 12 always zero
  always @* begin
    status_word = 16'h0000;
    status_word[`BIT_IRQ_SEL_HI] = tx_irq_select_ff[1];
    status_word[`BIT_IDLE_INVERT] = tx_idle_invert_ff;
    status_word[`BIT_IRQ_SEL_LO] = tx_irq_select_ff[0];
    status_word[`BIT_BREAK_REQ] = tx_break_request_ff;
    status_word[`BIT_TX_ENABLE] = tx_enable_bit_ff;
    status_word[`BIT_BUF_FULL] = fifo_full;
    status_word[`BIT_SHIFT_EMPTY] = tx_shift_empty_flag;
    status_word[`BIT_IR_ENABLE] = infrared_encode_enable_ff;
  end

  // Read data mux; the mask is write-only, so 0xc reads the status
  always @* begin
    nxt_rdata = 32'h0;
    nxt_rresp = `AXI_OKAY;
    case (s_axi_araddr)
      `ADDR_STATUS_CONTROL: begin
        nxt_rdata = {16'h0000, status_word};
      end
      `ADDR_BAUD_DIV: begin
        nxt_rdata = {16'h0000, baud_div_ff};
      end
      `ADDR_IRQ_STATUS: begin
        nxt_rdata = {30'h0, irq_status_ff};
      end
      default: begin
        nxt_rresp = `AXI_SLVERR;
      end
    endcase
  end

  // Read response register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  // Software fields; break request cleared by hardware when done
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq_select_ff <= 2'b00;
      tx_idle_invert_ff <= 1'b0;
      tx_break_request_ff <= 1'b0;
      tx_enable_bit_ff <= 1'b0;
      infrared_encode_enable_ff <= 1'b0;
      baud_div_ff <= `RST_BAUD_DIV;
      irq_mask_ff <= 2'b00;
    end else begin
      if (break_active_ff && shifter_done) begin
        tx_break_request_ff <= 1'b0;
      end
      if (!tx_enable_bit_ff) begin
        tx_break_request_ff <= 1'b0;
      end
      if (wr_fire && aw_addr_ff == `ADDR_STATUS_CONTROL) begin
        // Writes to bit 12 and to the status flags are dropped
        if (w_strb_ff[1]) begin
          tx_irq_select_ff <= {w_data_ff[`BIT_IRQ_SEL_HI], w_data_ff[`BIT_IRQ_SEL_LO]};
          tx_idle_invert_ff <= w_data_ff[`BIT_IDLE_INVERT];
          tx_enable_bit_ff <= w_data_ff[`BIT_TX_ENABLE];
          if (w_data_ff[`BIT_BREAK_REQ]) begin
            tx_break_request_ff <= 1'b1;
          end
        end
        if (w_strb_ff[0]) begin
          infrared_encode_enable_ff <= w_data_ff[`BIT_IR_ENABLE];
        end
      end
      if (wr_fire && aw_addr_ff == `ADDR_BAUD_DIV && w_strb_ff[0]) begin
        baud_div_ff <= w_data_ff[15:0];
      end
      if (wr_fire && aw_addr_ff == `ADDR_IRQ_MASK && w_strb_ff[0]) begin
        irq_mask_ff <= w_data_ff[1:0];
      end
    end
  end

  // ****************************************
  // Buffer and shifter
  // ****************************************

  // Disable flushes the buffer and aborts the frame
  tx_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!tx_enable_bit_ff),
    .in_valid(data_wr && tx_enable_bit_ff),
    .in_ready(fifo_in_ready),
    .in_data(w_data_ff[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(load_char),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // Break goes out as the next frame, ahead of queued data
  assign load_break = tx_enable_bit_ff && tx_break_request_ff && !break_active_ff;
  assign load_char = tx_enable_bit_ff && !shifter_busy && !load_break && fifo_out_valid;

  tx_shifter #(
    .DIV_W(16)
  ) u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .abort(!tx_enable_bit_ff),
    .div(baud_div_ff),
    .load((load_char || load_break) && !shifter_busy),
    .load_break(load_break),
    .load_data(fifo_out_data),
    .busy(shifter_busy),
    .done_ff(shifter_done),
    .line_ff(shifter_line)
  );

  // Break frame tracking
  always @(posedge aclk) begin
    if (!aresetn || !tx_enable_bit_ff) begin
      break_active_ff <= 1'b0;
    end else if (load_break && !shifter_busy) begin
      break_active_ff <= 1'b1;
    end else if (shifter_done) begin
      break_active_ff <= 1'b0;
    end
  end

  // Empty only when shifter idle and buffer empty
  // A break about to load counts as queued work
  assign tx_shift_empty_flag = !shifter_busy && fifo_empty && !shifter_done && !load_break;

  // ****************************************
  // Interrupt generation
  // ****************************************
  assign buf_push = data_wr && tx_enable_bit_ff && fifo_in_ready;
  assign buf_empty_after = load_char && (buf_level_ff == {{AW{1'b0}}, 1'b1});

  // Buffer level mirror; shows when a load takes the last character
  always @(posedge aclk) begin
    if (!aresetn || !tx_enable_bit_ff) begin
      buf_level_ff <= {(AW+1){1'b0}};
    end else if (buf_push && !load_char) begin
      buf_level_ff <= buf_level_ff + 1'b1;
    end else if (load_char && !buf_push) begin
      buf_level_ff <= buf_level_ff - 1'b1;
    end
  end

  // Event per select mode; 11 is left quiet
  assign tx_event = (tx_irq_select_ff == `IRQSEL_ANY_MOVE) ? load_char :
    (tx_irq_select_ff == `IRQSEL_BUF_EMPTY) ?
    buf_empty_after :
    (tx_irq_select_ff == `IRQSEL_ALL_DONE) ?
    (shifter_done && fifo_empty && !tx_break_request_ff) : 1'b0;

  // One-cycle pulse and sticky status; set beats read-clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq_pulse_ff <= 1'b0;
      irq_status_ff <= 2'b00;
    end else begin
      tx_irq_pulse_ff <= tx_event;
      irq_status_ff[0] <= tx_event ||
        (irq_status_ff[0] && !(rd_fire && s_axi_araddr == `ADDR_IRQ_STATUS));
      irq_status_ff[1] <= (break_active_ff && shifter_done) ||
        (irq_status_ff[1] && !(rd_fire && s_axi_araddr == `ADDR_IRQ_STATUS));
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // ****************************************
  // Line encoding
  // ****************************************

  // Encoded pulse: high for the first sixteenth of each zero bit
  always @(posedge aclk) begin
    if (!aresetn || shifter_line || !shifter_busy) begin
      ir_cnt_ff <= 16'h0;
      tx_ir_ff <= 1'b0;
    end else begin
      ir_cnt_ff <= (ir_cnt_ff == baud_div_ff) ? 16'h0 : ir_cnt_ff + 1'b1;
      tx_ir_ff <= (ir_cnt_ff < {4'h0, baud_div_ff[15:4]});
    end
  end

  // Idle polarity per mode
  assign plain_line = shifter_line ^ tx_idle_invert_ff;
  assign ir_line = tx_ir_ff ^ tx_idle_invert_ff;
  assign serial_tx_pin = infrared_encode_enable_ff ? ir_line : plain_line;
  assign tx_pin_owned = tx_enable_bit_ff;
endmodule

// ---- tb/uart_tx_checker.sv ----
// Port assertions for the serial transmit control block.
// Assumes one clock aclk and a synchronous active-low reset.
module uart_tx_checker #(parameter DEPTH = 4, parameter AW = 2) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Register bus
  input logic [3:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [3:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Line and interrupts
  input logic serial_tx_pin,
  input logic tx_pin_owned,
  input logic tx_irq_pulse_ff,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ra_ff;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire st_wr = wr_go && s_axi_awaddr == 4'h0;
  wire st_rd = s_axi_rvalid && ra_ff == 4'h0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address of the read in flight
  always_ff @(posedge aclk) begin
    if (ar_go) ra_ff <= s_axi_araddr;
  end
  // ****************************************
  // Checks
  // ****************************************
  // Bus answers and refusals
  a_write_answer: assert property (wr_go && s_axi_awaddr[1:0] == 2'h0 |->
    ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h0) else $error("write answer wrong");
  a_read_answer: assert property (ar_go && s_axi_araddr[1:0] == 2'h0 && s_axi_araddr != 4'h4 |->
    ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h0) else $error("read answer wrong");
  a_read_unmapped: assert property (ar_go && s_axi_araddr[1:0] != 2'h0 |->
    ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // Status fields and control effects
  a_bit12_zero: assert property (st_rd |-> !s_axi_rdata[12])
    else $error("bit 12 reads nonzero");
  a_full_empty: assert property (st_rd |-> !(s_axi_rdata[9] && s_axi_rdata[8]))
    else $error("full and empty together");
  a_irq_single: assert property (tx_irq_pulse_ff |=> !tx_irq_pulse_ff)
    else $error("interrupt pulse too long");
  a_pin_take: assert property (st_wr && s_axi_wdata[10] |-> ##[1:3] tx_pin_owned)
    else $error("pin not taken");
  a_pin_release: assert property (st_wr && !s_axi_wdata[10] |-> ##[1:3] !tx_pin_owned)
    else $error("pin not released");
  // Main scenarios
  c_break: cover property (st_rd && s_axi_rdata[11]);
  c_irq: cover property (irq);
  c_release: cover property ($fell(tx_pin_owned));
endmodule

bind uart_tx_status_control uart_tx_checker #(.DEPTH(DEPTH), .AW(AW)) u_uart_tx_checker (.*);

// ---- tb/uart_rx_model.sv ----
// Remote serial receiver that decodes frames on the transmit line.
// Assumes plain idle-high framing and a bit period of BIT clocks.
module uart_rx_model #(parameter int BIT = 4) (
  // Clock
  input logic aclk,
  // Serial line
  input logic line,
  input logic owned,
  // Decoded frame: byte, or break with its zero count
  output logic stb,
  output logic brk,
  output logic [7:0] val
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;
  logic ok;
  logic [13:0] sh;
  initial begin
    stb = 1'b0;
    brk = 1'b0;
    val = 8'h0;
  end
  // Hunt a start bit, sample mid-bit, drop the frame if the pin is let go
  always begin
    @(posedge aclk);
    stb <= 1'b0;
    if (owned === 1'b1 && line === 1'b0) begin
      repeat (BIT / 2) @(posedge aclk);
      ok = 1'b1;
      i = 0;
      while (ok && i < 14) begin
        repeat (BIT) @(posedge aclk);
        ok = (owned === 1'b1);
        sh[i] = line;
        if (ok && i >= 8 && line === 1'b1) break;
        i++;
      end
      if (ok) begin
        brk <= (i != 8);
        val <= (i == 8) ? sh[7:0] : 8'(i);
        stb <= 1'b1;
      end
    end
  end
endmodule

// ---- tb/uart_tx_status_control_tb.sv ----
// Self-checking bench for the serial transmit control and status block.
// Assumes the receiver model and the bound port checker.
module uart_tx_status_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  localparam int BIT = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic rx_on = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, d, cfg;
  logic serial_tx_pin, tx_pin_owned, tx_irq_pulse_ff, irq, rx_stb, rx_brk;
  logic [7:0] rx_val;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  int miscompares = 0;
  int cmp_count = 0;
  int pulses = 0;
  uart_tx_status_control #(.DEPTH(DEPTH), .AW(2)) u_uart_tx_status_control (.*);
  uart_rx_model #(.BIT(BIT)) u_uart_rx_model (.aclk(aclk), .line(serial_tx_pin),
    .owned(tx_pin_owned && rx_on), .stb(rx_stb), .brk(rx_brk), .val(rx_val));
  // Clock
  always #10 aclk = ~aclk;
  // Count interrupt pulses
  always @(posedge aclk) begin
    if (tx_irq_pulse_ff === 1'b1) pulses++;
  end
  // Compare each decoded frame with the oldest note
  always @(posedge aclk) begin
    if (rx_stb === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      chk("frame", 32'({rx_brk, rx_val}), 32'(e));
    end
  end
  // Overall hang guard
  initial begin
    repeat (90000) @(posedge aclk);
    tmo();
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo();
    miscompares++;
    finish_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    d = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // Poll status until shifter and buffer are both empty
  task automatic wait_empty();
    int n;
    n = 0;
    do begin
      repeat (BIT) @(posedge aclk);
      rd(4'h0);
      n++;
    end while (d[8] !== 1'b1 && n < 400);
    if (n >= 400) tmo();
  endtask
  // Write random bytes back to back, noting the first keep of them
  task automatic burst(input int cnt, input int keep);
    logic [8:0] b;
    for (int k = 0; k < cnt; k++) begin
      b = {1'b0, 8'($urandom)};
      wr(4'h4, {24'h0, b[7:0]});
      if (k < keep) exp_q.push_back(b);
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    void'($urandom(96));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0);
    chk("status_rst", d, 32'h100);
    chk("pins_rst", 32'({serial_tx_pin, tx_pin_owned, irq}), 32'h4);
    rd(4'h8);
    chk("baud_rst", d, 32'h1a);
    rd(4'h2);
    chk("unmapped_resp", 32'(rs), 32'h2);
    chk("unmapped_data", d, 32'h0);
    wr(4'h2, 32'h0);
    chk("wr_unmapped", 32'(rs), 32'h2);
    wr(4'h8, 32'(BIT - 1));
    chk("wr_resp", 32'(rs), 32'h0);
    wr(4'hc, 32'h3);
    // Receiver model sleeps while the idle level is low
    rx_on <= 1'b0;
    // Idle level for each invert and encode setting, bit 12 written as one
    for (int k = 0; k < 4; k++) begin
      cfg = 32'h0400 | (32'(k & 2) << 13) | 32'(k & 1);
      wr(4'h0, cfg | 32'h1000);
      repeat (2) @(posedge aclk);
      chk("idle", 32'(serial_tx_pin), 32'(k[1] == k[0]));
      chk("owned", 32'(tx_pin_owned), 32'h1);
      rd(4'h0);
      chk("status_rw", d, cfg | 32'h100);
    end
    rx_on <= 1'b1;
    // Select values 00, 01, 10 only
    for (int m = 0; m < 3; m++) begin
      wr(4'h0, 32'h0400 | (32'(m & 2) << 14) | (32'(m & 1) << 13));
      pulses = 0;
      burst(DEPTH + 2, DEPTH + 1);
      rd(4'h0);
      chk("busy_full", 32'(d[9:8]), 32'h2);
      wait_empty();
      repeat (BIT) @(posedge aclk);
      chk("drained", 32'(d[9:8]), 32'h1);
      chk("pulses", 32'(pulses), 32'(m == 0 ? DEPTH + 1 : m));
      chk("irq_set", 32'(irq), 32'h1);
      rd(4'hc);
      chk("irq_stat", d & 32'h1, 32'h1);
      rd(4'hc);
      @(posedge aclk);
      chk("irq_clr", 32'({irq, d[0]}), 32'h0);
    end
    // Break ahead of a queued byte, interrupt masked
    wr(4'hc, 32'h0);
    wr(4'h0, 32'h0c00);
    exp_q.push_back(9'h10c);
    rd(4'h0);
    chk("brk_pend", 32'(d[11]), 32'h1);
    burst(1, 1);
    wait_empty();
    chk("brk_done", 32'(d[11]), 32'h0);
    chk("irq_mask", 32'(irq), 32'h0);
    rd(4'hc);
    chk("brk_stat", d & 32'h2, 32'h2);
    wr(4'hc, 32'h3);
    // Disable in mid-frame: abort, flush, release, then resume
    burst(3, 0);
    repeat (10) @(posedge aclk);
    wr(4'h0, 32'h0);
    chk("released", 32'(tx_pin_owned), 32'h0);
    rd(4'h0);
    chk("flushed", 32'(d[9:8]), 32'h1);
    wr(4'h0, 32'h0400);
    repeat (20 * BIT) @(posedge aclk);
    burst(1, 1);
    wait_empty();
    repeat (4 * BIT) @(posedge aclk);
    chk("queue", 32'(exp_q.size()), 32'h0);
    finish_test();
  end
endmodule
